// ==== pkg/msp_params.svh ====
// constants for the master strobe and interrupt pin block
// assumes a 20 MHz reference clock
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
`define MSP_STYLE_ALT 1'h1
`define MSP_IRQ_W 16
`define MSP_CLK_MHZ 20
`define MSP_STROBE_SETUP_NS 50
`define MSP_SETUP_CYC (((`MSP_STROBE_SETUP_NS * `MSP_CLK_MHZ) + 999) / 1000)
`define MSP_WAIT_CNT_W 8
`define MSP_DIR_RST 1'h1
`define MSP_PINS_RST 4'hA
`define MSP_IRQ_RST 2'h2
`endif

// ==== pkg/msp_pkg.sv ====
// types for the master strobe and interrupt pin block
// shared by the pin driver and its interrupt combiner
`include "msp_params.svh"
package msp_pkg;
	typedef enum logic [1:0] {
		MSP_IDLE = 2'b00,
		MSP_SETUP = 2'b01,
		MSP_STROBE = 2'b10,
		MSP_END = 2'b11
	} msp_state_type;

	// one memory transfer request from the dma engine
	typedef struct packed {
		logic start;
		logic read;
	} msp_req_type;

	// pin group: strobe, direction and their enables
	typedef struct packed {
		logic cycle_strobe_n;
		logic cycle_strobe_oe;
		logic mem_read_not_write;
		logic mem_read_not_write_oe;
	} msp_pins_type;

	typedef struct packed {
		msp_state_type st;
		logic dir;
		logic [`MSP_WAIT_CNT_W-1:0] cnt;
		msp_pins_type pins;
		logic style_meta;
		logic style_sync;
		logic done;
	} msp_ctl_type;

	typedef struct packed {
		logic irq_n;
		logic irq_oe;
	} msp_irq_type;
endpackage

// ==== hdl/msp_irq.sv ====
// interrupt combiner: drives the open-drain interrupt request pin
// assumes status and mask come from registers on the same clock
`timescale 1ns/1ns
`include "msp_params.svh"
module msp_irq (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic [`MSP_IRQ_W-1:0] i_status,
	input wire logic [`MSP_IRQ_W-1:0] i_mask,
	output msp_pkg::msp_irq_type o_irq
);
	import msp_pkg::*;
	msp_irq_type irq_r;
	msp_irq_type irq_nxt;
	logic pend;

	always_comb begin
		pend = |(i_status & i_mask);
		irq_nxt.irq_n = ~(pend & i_enable);
		// open drain: only ever pulls low
		irq_nxt.irq_oe = pend & i_enable;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			irq_r <= `MSP_IRQ_RST;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign o_irq = irq_r;

	masked_quiet_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		((i_status & i_mask) == '0) |=> !o_irq.irq_oe)
		else $error("masked source drove interrupt");
	pend_irq_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_enable && (i_status & i_mask) != '0) |=> (o_irq.irq_oe && !o_irq.irq_n))
		else $error("pending enabled source missed");
endmodule

// ==== hdl/msp_top.sv ====
// bus master strobe, direction and interrupt pin driver
// assumes the dma engine holds address and status stable from i_req.start
// until o_done, and that i_owned reflects granted mastership on this clock
`timescale 1ns/1ns
`include "msp_params.svh"
module msp_top (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_bus_style_select,
	input wire logic i_owned,
	input wire msp_pkg::msp_req_type i_req,
	input wire logic i_term,
	input wire logic [`MSP_IRQ_W-1:0] i_status,
	input wire logic [`MSP_IRQ_W-1:0] i_mask,
	output msp_pkg::msp_pins_type o_pins,
	output logic o_busy,
	output logic o_done,
	output msp_pkg::msp_irq_type o_irq
);
	import msp_pkg::*;
	localparam logic [`MSP_WAIT_CNT_W-1:0] SETUP_CYC = `MSP_WAIT_CNT_W'(`MSP_SETUP_CYC);

	msp_ctl_type ctl_r;
	msp_ctl_type ctl_nxt;
	logic style_r;
	logic active;

	assign style_r = ctl_r.style_sync;
	assign active = (style_r == `MSP_STYLE_ALT) && i_owned;

	always_comb begin
		ctl_nxt = ctl_r;
		// strap pin is asynchronous: only the second flop is ever read
		ctl_nxt.style_meta = i_bus_style_select;
		ctl_nxt.style_sync = ctl_r.style_meta;
		ctl_nxt.done = 1'h0;
		case (ctl_r.st)
			MSP_IDLE: begin
				if (active && i_req.start) begin
					ctl_nxt.dir = i_req.read;
					ctl_nxt.cnt = SETUP_CYC;
					ctl_nxt.st = MSP_SETUP;
				end
			end
			MSP_SETUP: begin
				// address settles before the falling edge
				if (ctl_r.cnt > 8'h01) begin
					ctl_nxt.cnt = ctl_r.cnt - 8'h01;
				end else begin
					ctl_nxt.st = MSP_STROBE;
				end
			end
			MSP_STROBE: begin
				if (i_term) begin
					ctl_nxt.st = MSP_END;
				end
			end
			MSP_END: begin
				ctl_nxt.done = 1'h1;
				ctl_nxt.st = MSP_IDLE;
			end
			default: begin
				ctl_nxt.st = MSP_IDLE;
			end
		endcase
		// losing the bus aborts the cycle rather than hang it
		if (!active) begin
			ctl_nxt.st = MSP_IDLE;
		end
		ctl_nxt.pins.cycle_strobe_n = ~(ctl_nxt.st == MSP_STROBE);
		ctl_nxt.pins.cycle_strobe_oe = active;
		ctl_nxt.pins.mem_read_not_write = ctl_nxt.dir;
		ctl_nxt.pins.mem_read_not_write_oe = active;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			ctl_r <= '{st: MSP_IDLE, dir: `MSP_DIR_RST, cnt: 8'h00, pins: `MSP_PINS_RST,
				style_meta: 1'h0, style_sync: 1'h0, done: 1'h0};
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	assign o_pins = ctl_r.pins;
	assign o_busy = (ctl_r.st != MSP_IDLE);
	assign o_done = ctl_r.done;

	msp_irq u_irq (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_enable(style_r == `MSP_STYLE_ALT),
		.i_status(i_status),
		.i_mask(i_mask),
		.o_irq(o_irq)
	);

	strobe_after_setup_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$fell(o_pins.cycle_strobe_n)
		|-> $past(ctl_r.st) == MSP_SETUP)
		else $error("strobe fell without setup");

	strobe_rise_end_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_STROBE && i_term && active)
		|=> (o_pins.cycle_strobe_n ##1 o_done))
		else $error("strobe did not end cycle");

	dir_owned_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_pins.mem_read_not_write_oe
		|-> $past(active))
		else $error("direction driven without bus");

	dir_value_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_IDLE && active && i_req.start)
		|=> o_pins.mem_read_not_write == $past(i_req.read))
		else $error("direction wrong for transfer");

	pins_release_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!active
		|=> (!o_pins.cycle_strobe_oe && !o_pins.mem_read_not_write_oe))
		else $error("pins not released");

	style_gate_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(style_r != `MSP_STYLE_ALT)
		|=> (!o_pins.cycle_strobe_oe && !o_irq.irq_oe))
		else $error("pins active in other bus style");

	setup_high_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_SETUP)
		|-> o_pins.cycle_strobe_n)
		else $error("strobe low during address setup");

	setup_to_low_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_SETUP && ctl_r.cnt <= 8'h01 && active)
		|=> !o_pins.cycle_strobe_n)
		else $error("strobe did not fall after setup");

	take_to_setup_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_IDLE && active && i_req.start)
		|=> (ctl_r.st == MSP_SETUP && o_pins.cycle_strobe_n))
		else $error("strobe fell before address setup");

	strobe_hold_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(!o_pins.cycle_strobe_n && !i_term && active)
		|=> !o_pins.cycle_strobe_n)
		else $error("strobe rose without termination");

	end_high_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st == MSP_END)
		|-> o_pins.cycle_strobe_n)
		else $error("strobe low at cycle end");

	done_once_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_done
		|=> !o_done)
		else $error("done longer than one cycle");

	done_from_end_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_done
		|-> $past(ctl_r.st) == MSP_END)
		else $error("done without a finished cycle");

	dir_stable_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(ctl_r.st != MSP_IDLE)
		|=> $stable(o_pins.mem_read_not_write))
		else $error("direction changed inside a cycle");

	dir_oe_pair_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_pins.mem_read_not_write_oe
		== o_pins.cycle_strobe_oe)
		else $error("direction and strobe enables differ");

	strobe_drive_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!o_pins.cycle_strobe_n
		|-> o_pins.cycle_strobe_oe)
		else $error("strobe low while released");

	busy_drive_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_busy
		|-> o_pins.cycle_strobe_oe)
		else $error("cycle running without the bus");

	abort_clean_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(!active && ctl_r.st == MSP_STROBE)
		|=> (o_pins.cycle_strobe_n && !o_busy && !o_done))
		else $error("lost bus did not abort cleanly");

	style_dir_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(style_r != `MSP_STYLE_ALT)
		|=> !o_pins.mem_read_not_write_oe)
		else $error("direction driven in other bus style");

	style_irq_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(style_r != `MSP_STYLE_ALT)
		|=> o_irq.irq_n)
		else $error("interrupt active in other bus style");

	reset_quiet_a: assert property (
		@(posedge i_ref_clk)
		!i_nrst
		|=> (!o_pins.cycle_strobe_oe && !o_pins.mem_read_not_write_oe && !o_busy && !o_done))
		else $error("pins driven out of reset");

	irq_pending_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(style_r == `MSP_STYLE_ALT && (i_status & i_mask) != '0)
		|=> !o_irq.irq_n)
		else $error("enabled pending source not signalled");

	irq_masked_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_nrst)
		((i_status & i_mask) == '0)
		|=> o_irq.irq_n)
		else $error("interrupt active with all sources masked");
endmodule

// ==== sim/msp_mem_model.sv ====
// memory side model: ends each strobe after a set wait
// assumes the pins come straight from the block on the same clock
`timescale 1ns/1ns
module msp_mem_model (
	input wire logic i_ref_clk,
	input wire logic [3:0] i_wait,
	input wire msp_pkg::msp_pins_type i_pins,
	output logic o_term
);
	import msp_pkg::*;
	logic [3:0] cnt_r;
	wire logic low = i_pins.cycle_strobe_oe && !i_pins.cycle_strobe_n;
	always_ff @(posedge i_ref_clk) begin
		cnt_r <= low ? cnt_r + 4'h1 : 4'h0;
	end
	// term only while a strobe is out, so it never lingers into idle
	assign o_term = low && cnt_r >= i_wait;
endmodule

// ==== sim/master_strobe_and_irq_pins_bench.sv ====
// random transfers, ownership loss and style checks on the pin block
// assumes the memory model answers each strobe
`timescale 1ns/1ns
module master_strobe_and_irq_pins_bench;
	import msp_pkg::*;
	logic clk = 0, nrst = 0, style = 1, owned = 1, term, busy, done;
	msp_req_type req = '0;
	logic [15:0] st = 16'h0000, mk = 16'h0000;
	msp_pins_type pins;
	msp_irq_type irq;
	logic [3:0] wt = 4'h0;
	int fails = 0, comparisons = 0, seed = 90, k;
	always #25 clk = ~clk;
	msp_top u_msp_top (.i_ref_clk(clk), .i_nrst(nrst), .i_bus_style_select(style),
		.i_owned(owned), .i_req(req), .i_term(term), .i_status(st), .i_mask(mk),
		.o_pins(pins), .o_busy(busy), .o_done(done), .o_irq(irq));
	msp_mem_model u_msp_mem_model (.i_ref_clk(clk), .i_wait(wt), .i_pins(pins), .o_term(term));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic rd);
		req = '{start: 1'b1, read: rd};
		cyc(1);
		req.start = 1'b0;
		chk(pins.cycle_strobe_n, 1);
		k = 0;
		while (pins.cycle_strobe_n !== 1'b0 && k < 20) begin
			cyc(1);
			k++;
		end
		chk(pins.mem_read_not_write, rd);
		chk(pins.mem_read_not_write_oe, 1);
		chk(pins.cycle_strobe_oe, 1);
		chk(busy, 1);
		k = 0;
		while (done !== 1'b1 && k < 30) begin
			cyc(1);
			k++;
		end
		chk(pins.cycle_strobe_n, 1);
		chk(done, 1);
		chk(busy, 0);
	endtask
	initial begin
		cyc(2);
		nrst = 1;
		cyc(3);
		for (int i = 0; i < 12; i++) begin
			wt = 4'($random(seed) & 7);
			st = (i == 0) ? 16'hFFFF : 16'($random(seed));
			mk = (i == 0) ? 16'h0000 : 16'($random(seed));
			xfer(1'($random(seed)));
			chk(irq.irq_oe, |(st & mk));
			chk(irq.irq_n, !(|(st & mk)));
		end
		$display("transfers done");
		wt = 4'hF; // stall so the loss of ownership lands mid-strobe
		req = '{start: 1'b1, read: 1'b0};
		cyc(1);
		req.start = 1'b0;
		cyc(2);
		chk(pins.cycle_strobe_n, 0);
		owned = 0;
		cyc(3);
		chk(pins.cycle_strobe_oe, 0);
		chk(pins.mem_read_not_write_oe, 0);
		chk(done, 0);
		chk(busy, 0);
		$display("release done");
		owned = 1;
		style = 0;
		st = 16'hFFFF;
		mk = 16'hFFFF;
		req.start = 1'b1;
		cyc(5);
		chk(irq.irq_oe, 0);
		chk(pins.cycle_strobe_oe, 0);
		$display("style done");
		finish_test;
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		finish_test;
	end
endmodule
